// File: muxed_io_bus_idle_cycle_ctrl.sv
// Purpose: Multiplexed address/data bus cycle and idle cycle sequencer
// Assumes: Requests and WAIT are synchronous to clk
// Notes: A request is held until accDone pulses
`timescale 1ns/1ps
module muxed_io_bus_idle_cycle_ctrl
   import mux_bus_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic accReq,
   input wire logic accWrite,
   input wire logic [AREA_W-1:0] accArea,
   input wire logic [15:0] accAddr,
   input wire logic [15:0] accWdata,
   input wire logic [7:0] area_muxed_enable,
   input wire logic [7:0] area_width_16,
   input wire logic addr_phase_extend,
   input wire logic [WAIT_W-1:0] waitStates,
   input wire logic waitPinN,
   input wire logic read_strobe_negate_late,
   input wire logic csExtendPre,
   input wire logic csExtendPost,
   input wire logic [2:0] idleEnIn,
   input wire logic [1:0] idleCountAIn,
   input wire logic [1:0] idleCountBIn,
   input wire logic [7:0] idleSelIn,
   input wire logic idleCfgWrite,
   input wire logic [15:0] adIn,
   output logic [15:0] adOut,
   output logic [15:0] adOe,
   output logic area_chip_select_n,
   output logic addr_hold_strobe_n,
   output logic readStrobeN,
   output logic writeHighN,
   output logic writeLowN,
   output logic accDone,
   output logic [15:0] accRdata,
   output logic [2:0] idleEn,
   output logic [1:0] idleCountA,
   output logic [1:0] idleCountB,
   output logic [7:0] idleSel
);
   bus_state_t state_q;
   logic prevValid_q, prevWrite_q;
   logic [AREA_W-1:0] prevArea_q;
   logic [IDLE_W-1:0] gapCnt_q;
   logic [WAIT_W-1:0] waitCnt_q;
   logic [IDLE_W-1:0] cyclesA, cyclesB, idleNeed;
   logic isWide, isMux, useB, muxPrev;
   logic rdLate_q;

   // ------------------------------------------------------------
   // Idle configuration
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         idleEn <= IDLE_EN_RST;
         idleCountA <= IDLE_CNT_RST;
         idleCountB <= IDLE_CNT_RST;
         idleSel <= IDLE_SEL_RST;
      end
      else if (idleCfgWrite)
      begin
         idleEn <= idleEnIn;
         idleCountA <= idleCountAIn;
         idleCountB <= idleCountBIn;
         idleSel <= idleSelIn;
      end
   end

   idle_count_decode decA (
      .code(idleCountA),
      .isSettingB(1'b0),
      .cycles(cyclesA)
   );
   idle_count_decode decB (
      .code(idleCountB),
      .isSettingB(1'b1),
      .cycles(cyclesB)
   );

   // ------------------------------------------------------------
   // Idle requirement for the pending access
   // ------------------------------------------------------------
   always_comb
   begin
      useB = idleSel[prevArea_q];
      idleNeed = IDLE_ZERO;
      if (prevValid_q && !prevWrite_q && !accWrite
          && prevArea_q != accArea && idleEn[IDLE_EN_RR])
         idleNeed = useB ? cyclesB : cyclesA;
      else if (prevValid_q && !prevWrite_q && accWrite
               && idleEn[IDLE_EN_WAR])
         idleNeed = useB ? cyclesB : cyclesA;
      else if (prevValid_q && prevWrite_q && !accWrite
               && idleEn[IDLE_EN_RAW])
         idleNeed = cyclesA;
      isWide = area_width_16[accArea];
      isMux = area_muxed_enable[accArea] && MUX_AREA_MASK[accArea];
      // The request may already name the next access during the
      // trailing extension, so that state uses the finished area
      muxPrev = area_muxed_enable[prevArea_q] && MUX_AREA_MASK[prevArea_q];
   end

   // Gap counter runs in every cycle without a bus state, so
   // cycles with no external access already count as idle
   always_ff @(posedge clk)
   begin
      if (!nrst)
         gapCnt_q <= IDLE_MAX;
      else if (state_q == ST_IDLE || state_q == ST_GAP)
      begin
         if (gapCnt_q != IDLE_MAX)
            gapCnt_q <= gapCnt_q + IDLE_ONE;
      end
      else
         gapCnt_q <= IDLE_ZERO;
   end

   // ------------------------------------------------------------
   // Bus cycle sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         waitCnt_q <= WAIT_ZERO;
         prevValid_q <= 1'b0;
         prevWrite_q <= 1'b0;
         prevArea_q <= '0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE, ST_GAP:
               if (accReq)
               begin
                  if (gapCnt_q < idleNeed)
                     state_q <= ST_GAP;
                  else if (csExtendPre)
                     state_q <= ST_EXT_PRE;
                  else
                     state_q <= ST_ADDR1;
               end
               else
                  state_q <= ST_IDLE;
            ST_EXT_PRE:
               state_q <= ST_ADDR1;
            ST_ADDR1:
               state_q <= addr_phase_extend ? ST_ADDRW : ST_ADDR2;
            ST_ADDRW:
               state_q <= ST_ADDR2;
            ST_ADDR2:
            begin
               state_q <= ST_DATA1;
               waitCnt_q <= waitStates;
            end
            ST_DATA1:
               state_q <= ST_DATA2;
            ST_DATA2:
               if (waitCnt_q != WAIT_ZERO)
                  waitCnt_q <= waitCnt_q - WAIT_ONE;
               else if (waitPinN)
               begin
                  state_q <= csExtendPost ? ST_EXT_POST : ST_IDLE;
                  prevValid_q <= 1'b1;
                  prevWrite_q <= accWrite;
                  prevArea_q <= accArea;
               end
            ST_EXT_POST:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         adOut <= '0;
         adOe <= '0;
         area_chip_select_n <= 1'b1;
         addr_hold_strobe_n <= 1'b1;
         readStrobeN <= 1'b1;
         writeHighN <= 1'b1;
         writeLowN <= 1'b1;
         accDone <= 1'b0;
         accRdata <= '0;
         rdLate_q <= 1'b0;
      end
      else
      begin
         accDone <= 1'b0;
         rdLate_q <= 1'b0;
         area_chip_select_n <= !((isMux && (state_q == ST_EXT_PRE
            || state_q == ST_ADDR1 || state_q == ST_ADDRW
            || state_q == ST_ADDR2 || state_q == ST_DATA1
            || state_q == ST_DATA2))
            || (muxPrev && state_q == ST_EXT_POST));
         addr_hold_strobe_n <= !(state_q == ST_ADDR1
            || state_q == ST_ADDRW);
         if (state_q == ST_ADDR1 || state_q == ST_ADDRW
             || state_q == ST_ADDR2)
         begin
            adOut <= isWide ? accAddr : {8'h00, accAddr[7:0]};
            adOe <= isWide ? 16'hFFFF : 16'h00FF;
         end
         else if ((state_q == ST_DATA1 || state_q == ST_DATA2) && accWrite)
         begin
            adOut <= isWide ? accWdata : {8'h00, accWdata[7:0]};
            adOe <= isWide ? 16'hFFFF : 16'h00FF;
         end
         else
            adOe <= '0;
         readStrobeN <= !((!accWrite && (state_q == ST_DATA1
            || state_q == ST_DATA2)) || rdLate_q);
         writeHighN <= !(accWrite && isWide && state_q == ST_DATA1);
         writeLowN <= !(accWrite && state_q == ST_DATA1);
         if (state_q == ST_DATA2 && waitCnt_q == WAIT_ZERO && waitPinN)
         begin
            accDone <= 1'b1;
            // Late negation keeps the strobe one more cycle
            rdLate_q <= !accWrite && read_strobe_negate_late;
            accRdata <= isWide ? adIn : {8'h00, adIn[7:0]};
         end
      end
   end
endmodule

// File: mux_bus_pkg.sv
// Purpose: Shared constants for the multiplexed I/O bus sequencer
// Assumes: One 10 MHz bus clock
// Notes: Idle count encodings and reset values live here
package mux_bus_pkg;
   localparam int AREA_CNT = 8;
   localparam int AREA_W = 3;
   localparam int IDLE_W = 3;
   localparam int WAIT_W = 3;
   // Idle enable bit positions
   localparam int IDLE_EN_WAR = 0;
   localparam int IDLE_EN_RR = 1;
   localparam int IDLE_EN_RAW = 2;
   localparam logic [2:0] IDLE_EN_RST = 3'h7;
   localparam logic [1:0] IDLE_CNT_RST = 2'h3;
   localparam logic [7:0] IDLE_SEL_RST = 8'h00;
   localparam logic [7:0] MUX_AREA_MASK = 8'hF8;
   localparam logic [IDLE_W-1:0] IDLE_MAX = 3'h4;
   localparam logic [IDLE_W-1:0] IDLE_ONE = 3'h1;
   localparam logic [IDLE_W-1:0] IDLE_ZERO = 3'h0;
   localparam logic [WAIT_W-1:0] WAIT_ZERO = 3'h0;
   localparam logic [WAIT_W-1:0] WAIT_ONE = 3'h1;
   localparam logic [1:0] CNT_CODE0 = 2'h0;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_GAP = 9'h002,
      ST_EXT_PRE = 9'h004,
      ST_ADDR1 = 9'h008,
      ST_ADDRW = 9'h010,
      ST_ADDR2 = 9'h020,
      ST_DATA1 = 9'h040,
      ST_DATA2 = 9'h080,
      ST_EXT_POST = 9'h100
   } bus_state_t;
endpackage

// File: idle_count_decode.sv
// Purpose: Decode 2-bit idle count settings into a cycle count
// Assumes: Combinational use only
// Notes: Setting B code 0 means no idle cycle
`timescale 1ns/1ps
module idle_count_decode
   import mux_bus_pkg::*;
(
   input wire logic [1:0] code,
   input wire logic isSettingB,
   output logic [IDLE_W-1:0] cycles
);
   always_comb
   begin
      if (isSettingB && code == CNT_CODE0)
         cycles = IDLE_ZERO;
      else
         cycles = IDLE_W'({1'b0, code}) + IDLE_ONE;
   end
endmodule

// File: mux_bus_checker.sv
// Purpose: Port assertions for the muxed bus sequencer
// Assumes: Sync active-low reset nrst
// Notes: Bound by name to the top module
`timescale 1ns/1ps
module mux_bus_checker
   import mux_bus_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic accReq,
   input wire logic idleCfgWrite,
   input wire logic [2:0] idleEnIn,
   input wire logic [1:0] idleCountAIn,
   input wire logic [15:0] adOe,
   input wire logic area_chip_select_n,
   input wire logic addr_hold_strobe_n,
   input wire logic readStrobeN,
   input wire logic writeLowN,
   input wire logic writeHighN,
   input wire logic read_strobe_negate_late,
   input wire logic accDone,
   input wire logic [2:0] idleEn,
   input wire logic [1:0] idleCountA
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_reset_config: assert property (disable iff (1'b0) !nrst |=>
      idleEn == IDLE_EN_RST && idleCountA == IDLE_CNT_RST)
      else $error("idle config not at reset value");
   a_reset_pins: assert property (disable iff (1'b0) !nrst |=>
      readStrobeN && adOe == 16'h0000 && !accDone)
      else $error("pins active after reset");
   a_config_load: assert property (idleCfgWrite |=>
      idleEn == $past(idleEnIn) && idleCountA == $past(idleCountAIn))
      else $error("idle config not loaded");
   a_done_pulse: assert property (accDone |=> !accDone)
      else $error("done longer than one cycle");
   a_hold_no_write: assert property (!addr_hold_strobe_n |-> writeLowN)
      else $error("write strobe in address phase");
   a_hold_has_select: assert property (
      !addr_hold_strobe_n |-> !area_chip_select_n)
      else $error("address hold without select");
   a_idle_bound: assert property (accDone ##1 accReq |->
      ##[1:10] $fell(addr_hold_strobe_n))
      else $error("next access started too late");
   a_write_drives: assert property (!writeLowN |-> adOe[7:0] == 8'hFF)
      else $error("write data not driven");
   a_high_write_drives: assert property (
      !writeHighN |-> adOe[15:8] == 8'hFF)
      else $error("upper write strobe without upper data");
   a_late_negate: assert property (
      accDone && !readStrobeN && read_strobe_negate_late |=> !readStrobeN)
      else $error("late read strobe negation missing");
   cover property (idleCfgWrite);
   cover property ($fell(readStrobeN));
   cover property ($fell(writeLowN));
endmodule
bind muxed_io_bus_idle_cycle_ctrl mux_bus_checker chk (.*);

// File: mux_peripheral.sv
// Purpose: Muxed address/data peripheral facing the sequencer
// Assumes: Reads return the latched address xor 5A3C
// Notes: Released data lines toggle so stale values never match
`timescale 1ns/1ps
module mux_peripheral
(
   input wire logic clk,
   input wire logic slow,
   input wire logic [15:0] adOut,
   input wire logic [15:0] adOe,
   input wire logic addr_hold_strobe_n,
   input wire logic readStrobeN,
   input wire logic writeLowN,
   output logic [15:0] adIn,
   output logic waitPinN,
   output logic [15:0] lastWr
);
   logic [15:0] addr_q = 16'h0000;
   logic [15:0] junk_q = 16'hA5A5;
   logic [1:0] stall_q = 2'h0;
   initial lastWr = 16'h0000;
   always @(posedge clk)
   begin
      junk_q <= ~junk_q;
      if (!addr_hold_strobe_n)
         addr_q <= adOut & adOe;
      if (!writeLowN)
         lastWr <= adOut & adOe;
      stall_q <= readStrobeN ? 2'h0 : stall_q + 2'(stall_q != 2'h3);
   end
   // Slow mode holds the wait pin for the first two strobe cycles
   assign waitPinN = !(slow && !readStrobeN && stall_q < 2'h2);
   assign adIn = readStrobeN ? junk_q : addr_q ^ 16'h5A3C;
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the muxed bus sequencer
// Assumes: Peer answers reads with the latched address xor 5A3C
// Notes: Idle counts are judged by spacing of address strobes
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0, nrst = 1'b0, accReq = 1'b0, accWrite = 1'b0;
   logic addr_phase_extend = 1'b0, read_strobe_negate_late = 1'b0;
   logic csExtendPre = 1'b0, csExtendPost = 1'b0, idleCfgWrite = 1'b0;
   logic slow = 1'b0, ahLast_q = 1'b1, rdLast_q = 1'b1, waitPinN, accDone;
   logic area_chip_select_n, addr_hold_strobe_n, readStrobeN;
   logic writeHighN, writeLowN;
   logic [2:0] accArea = 3'h0, waitStates = 3'h0, idleEnIn = 3'h0, idleEn;
   logic [1:0] idleCountAIn = 2'h0, idleCountBIn = 2'h0;
   logic [1:0] idleCountA, idleCountB;
   logic [7:0] idleSelIn = 8'h00, idleSel;
   logic [7:0] area_muxed_enable = 8'hF8;
   logic [7:0] area_width_16 = 8'hF7;
   logic [15:0] accAddr = 16'h0000, accWdata = 16'h0000, accRdata;
   logic [15:0] adIn, adOut, adOe, lastWr;
   int err_count = 0, samples_checked = 0, cyc = 0, ah = 0, ahP = 0;
   int rd = 0, sp, d, s0, sw, d0, ru = 0, rl, rl0;
   always #50 clk = ~clk;
   muxed_io_bus_idle_cycle_ctrl uut (.*);
   mux_peripheral peer (.*);
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      ahLast_q <= addr_hold_strobe_n;
      rdLast_q <= readStrobeN;
      if (ahLast_q && !addr_hold_strobe_n)
      begin
         ahP <= ah;
         ah <= cyc;
      end
      if (rdLast_q && !readStrobeN)
         rd <= cyc;
      if (!rdLast_q && readStrobeN)
         ru <= cyc;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic nop(input int k);
      accReq = 1'b0;
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic cfg(input logic [2:0] en, input logic [1:0] a,
      input logic [1:0] b, input logic [7:0] sel);
      idleEnIn = en;
      idleCountAIn = a;
      idleCountBIn = b;
      idleSelIn = sel;
      idleCfgWrite = 1'b1;
      @(posedge clk);
      #1;
      idleCfgWrite = 1'b0;
   endtask
   task automatic acc(input logic w, input logic [2:0] a);
      logic [15:0] x;
      int n;
      n = 0;
      accReq = 1'b1;
      accWrite = w;
      accArea = a;
      accAddr = 16'hC3A5 + 16'(a);
      accWdata = ~accAddr;
      x = w ? ~accAddr : accAddr ^ 16'h5A3C;
      if (!area_width_16[a])
         x[15:8] = 8'h00;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end while (accDone !== 1'b1 && n < 60);
      if (n >= 60)
      begin
         err_count++;
         give_verdict();
      end
      chk(w ? lastWr : accRdata, x);
   endtask
   task automatic pair(input logic w1, input logic [2:0] a1, input logic w2,
      input logic [2:0] a2, input int k);
      acc(w1, a1);
      if (k > 0)
         nop(k);
      acc(w2, a2);
      nop(6);
      sp = ah - ahP;
      d = rd - ah;
      rl = ru - rd;
   endtask
   task automatic pc(input logic w1, input logic [2:0] a1, input logic w2,
      input logic [2:0] a2, input int k, input int e);
      pair(w1, a1, w2, a2, k);
      chk(16'(sp), 16'(e));
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      #1;
      nrst = 1'b1;
      chk({1'b0, idleEn, idleCountA, idleCountB, idleSel}, 16'h7F00);
      pair(0, 4, 0, 4, 0);
      s0 = sp;
      d0 = d;
      rl0 = rl;
      pair(1, 4, 1, 4, 0);
      sw = sp;
      pc(0, 4, 0, 5, 0, s0 + 4);
      for (int c = 0; c < 4; c++)
      begin
         cfg(3'h7, 2'(c), 2'(c), 8'h00);
         pc(0, 4, 0, 5, 0, s0 + c + 1);
         cfg(3'h7, 2'(c), 2'(c), 8'h10);
         pc(0, 4, 1, 4, 0, s0 + (c == 0 ? 0 : c + 1));
      end
      cfg(3'h7, 2'h3, 2'h0, 8'h20);
      pc(0, 4, 0, 5, 0, s0 + 4);
      cfg(3'h1, 2'h1, 2'h0, 8'h00);
      pc(0, 4, 1, 4, 0, s0 + 2);
      pc(0, 4, 0, 5, 0, s0);
      pc(1, 4, 0, 4, 0, sw);
      cfg(3'h4, 2'h2, 2'h0, 8'hFF);
      pc(1, 4, 0, 4, 0, sw + 3);
      pc(0, 4, 1, 4, 0, s0);
      cfg(3'h7, 2'h3, 2'h0, 8'h00);
      pc(0, 4, 0, 5, 2, s0 + 4);
      pc(0, 4, 0, 5, 6, s0 + 6);
      addr_phase_extend = 1'b1;
      pc(0, 4, 0, 4, 0, s0 + 1);
      chk(16'(d), 16'(d0 + 1));
      addr_phase_extend = 1'b0;
      waitStates = 3'h2;
      pc(0, 4, 0, 4, 0, s0 + 2);
      chk(16'(d), 16'(d0));
      waitStates = 3'h0;
      csExtendPre = 1'b1;
      csExtendPost = 1'b1;
      pc(0, 4, 0, 4, 0, s0 + 2);
      csExtendPre = 1'b0;
      csExtendPost = 1'b0;
      read_strobe_negate_late = 1'b1;
      slow = 1'b1;
      pair(0, 4, 0, 4, 0);
      chk(16'(sp), 16'(s0 + 2));
      chk(16'(rl), 16'(rl0 + 3));
      read_strobe_negate_late = 1'b0;
      slow = 1'b0;
      pair(0, 3, 1, 3, 0);
      give_verdict();
   end
endmodule
